// [src/lcs_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module lcs_cell (
  input  wire logic        clock_i,             // System clock, 100 MHz
  input  wire logic        rst_n_i,             // Synchronous reset, active low
  input  wire logic        ce_i,                // Freezes all state when low
  input  wire logic [7:0]  reg_addr_i,          // Register byte address
  input  wire logic [31:0] reg_wdata_i,         // Register write data
  input  wire logic        reg_we_i,            // Register write strobe
  input  wire logic        reg_re_i,            // Register read strobe
  output logic      [31:0] reg_rdata_o,         // Read data, cycle after strobe
  input  wire logic        cell_clk_i,          // Shared cell clock level
  input  wire logic        store_clk_en_i,      // Shared storage clock enable
  input  wire logic        local_set_reset_i,   // Local set/reset, active high
  input  wire logic        global_init_pulse_i, // Global set/reset, active high
  input  wire logic        din_lo_i,            // Low data pin
  input  wire logic        din_hi_i,            // High data pin
  input  wire logic [3:0]  first_gen_addr_i,    // First generator address
  input  wire logic [3:0]  second_gen_addr_i,   // Second generator address
  input  wire logic        ram_we_i,            // RAM write enable
  output logic      [1:0]  q_o,                 // Storage element outputs
  output logic             f_out_o,             // First generator RAM out
  output logic             g_out_o,             // Second generator RAM out
  output logic             h_out_o,             // Third generator out
  output logic             port_read_out_o      // Single-port RAM data out
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [lcs_pkg::CFG_W-1:0]  cfg;
  logic [lcs_pkg::CFG_W-1:0]  next_cfg;
  logic [31:0]                next_rdata;
  logic [lcs_pkg::STAT_W-1:0] status;
  logic                       k_prev;
  logic                       next_k_prev;
  lcs_pkg::lcs_wr_t           wr_state;
  lcs_pkg::lcs_wr_t           next_wr_state;

  assign status = {port_read_out_o, wr_state, k_prev, q_o};

  always_comb begin
    next_cfg   = cfg;
    next_rdata = 32'h0;
    if (reg_we_i && reg_addr_i == lcs_pkg::OFF_CFG) begin
      next_cfg = reg_wdata_i[lcs_pkg::CFG_W-1:0];
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        lcs_pkg::OFF_CFG:  next_rdata = {{(32-lcs_pkg::CFG_W){1'b0}}, cfg};
        lcs_pkg::OFF_STAT: next_rdata = {{(32-lcs_pkg::STAT_W){1'b0}}, status};
        default:           next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg         <= lcs_pkg::CFG_RESET;
      reg_rdata_o <= 32'h0;
    end else if (ce_i) begin
      cfg         <= next_cfg;
      reg_rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Cell clock edge tracking
  // ---------------------------------------------------------------
  logic [1:0] ram_mode;
  logic       mode32;
  logic       ram_on;
  logic       wclk_edge;

  assign next_k_prev = cell_clk_i;
  assign ram_mode    = cfg[lcs_pkg::CFG_RAM_MODE +: 2];
  assign mode32      = (ram_mode == lcs_pkg::RAM_32);
  assign ram_on      = mode32 || (ram_mode == lcs_pkg::RAM_16);
  assign wclk_edge   = cfg[lcs_pkg::CFG_WCLK_FALL] ? (k_prev && !cell_clk_i)
                                                   : (!k_prev && cell_clk_i);

  // ---------------------------------------------------------------
  // RAM write capture and internal pulse
  // ---------------------------------------------------------------
  logic [3:0] wr_addr [2];
  logic [3:0] next_wr_addr [2];
  logic [1:0] wr_data;
  logic [1:0] next_wr_data;
  logic [1:0] wr_en;
  logic [1:0] next_wr_en;
  logic       capture;

  assign capture = wclk_edge && ram_on && ram_we_i;

  always_comb begin
    next_wr_state   = lcs_pkg::LCS_WR_IDLE;
    next_wr_addr[0] = wr_addr[0];
    next_wr_addr[1] = wr_addr[1];
    next_wr_data    = wr_data;
    next_wr_en      = wr_en;
    case (wr_state)
      lcs_pkg::LCS_WR_IDLE:  next_wr_state = lcs_pkg::LCS_WR_IDLE;
      lcs_pkg::LCS_WR_PULSE: next_wr_state = lcs_pkg::LCS_WR_IDLE;
      default:               next_wr_state = lcs_pkg::LCS_WR_IDLE;
    endcase
    if (capture) begin
      next_wr_state = lcs_pkg::LCS_WR_PULSE;
      if (mode32) begin
        // shared low address, high pin picks generator
        next_wr_addr[0] = first_gen_addr_i;
        next_wr_addr[1] = first_gen_addr_i;
        next_wr_data    = {din_lo_i, din_lo_i};
        next_wr_en      = {din_hi_i, !din_hi_i};
      end else begin
        // each generator own address and data pin
        next_wr_addr[0] = first_gen_addr_i;
        next_wr_addr[1] = second_gen_addr_i;
        next_wr_data    = {din_hi_i, din_lo_i};
        next_wr_en      = 2'h3;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      k_prev     <= 1'h0;
      wr_state   <= lcs_pkg::LCS_WR_IDLE;
      wr_addr[0] <= 4'h0;
      wr_addr[1] <= 4'h0;
      wr_data    <= 2'h0;
      wr_en      <= 2'h0;
    end else if (ce_i) begin
      k_prev     <= next_k_prev;
      wr_state   <= next_wr_state;
      wr_addr    <= next_wr_addr;
      wr_data    <= next_wr_data;
      wr_en      <= next_wr_en;
    end
  end

  // ---------------------------------------------------------------
  // Generator RAMs (16 bits each)
  // ---------------------------------------------------------------
  logic [1:0] ram_out;
  logic [3:0] rd_addr [2];

  assign rd_addr[0] = first_gen_addr_i;
  assign rd_addr[1] = mode32 ? first_gen_addr_i : second_gen_addr_i;

  // one write pulse serves both generators
  for (genvar g = 0; g < 2; g++) begin : gen_ram
    logic [15:0] bits;
    logic [15:0] next_bits;
    logic        rd_wr;

    assign rd_wr = bits[wr_addr[g]];

    always_comb begin
      next_bits = bits;
      if (wr_state == lcs_pkg::LCS_WR_PULSE && wr_en[g]) begin
        next_bits[wr_addr[g]] = wr_data[g];
      end
    end

    // Contents survive reset, as a real distributed RAM would
    always_ff @(posedge clock_i) begin
      if (ce_i) begin
        bits <= next_bits;
      end
    end

    assign ram_out[g] = bits[rd_addr[g]];
  end

  assign f_out_o         = ram_out[0];
  assign g_out_o         = ram_out[1];
  assign port_read_out_o = mode32 ? (din_hi_i ? ram_out[1] : ram_out[0]) : ram_out[0];
  // third generator of both outputs and high pin
  assign h_out_o         = cfg[lcs_pkg::CFG_HLUT + {29'h0, din_hi_i, ram_out[1], ram_out[0]}];

  // ---------------------------------------------------------------
  // Storage elements
  // ---------------------------------------------------------------
  logic [1:0] next_q;
  logic [1:0] force_q;
  logic [1:0] en_q;
  logic [1:0] edge_q;
  logic [1:0] keff_q;
  logic [1:0] d_q;

  for (genvar n = 0; n < 2; n++) begin : gen_store
    logic [1:0] src;
    logic       kprev_eff;

    assign src       = cfg[lcs_pkg::CFG_SRC + 2*n +: 2];
    assign keff_q[n] = cell_clk_i ^ cfg[lcs_pkg::CFG_CLK_INV + n];
    assign kprev_eff = k_prev ^ cfg[lcs_pkg::CFG_CLK_INV + n];
    assign edge_q[n] = keff_q[n] && !kprev_eff;
    // enable used in true sense only
    assign en_q[n]   = store_clk_en_i || !cfg[lcs_pkg::CFG_CE_USED + n];
    assign force_q[n] = global_init_pulse_i
                        || (local_set_reset_i && cfg[lcs_pkg::CFG_SR_USED + n]);

    always_comb begin
      case (src)
        lcs_pkg::SRC_DIN_LO: d_q[n] = din_lo_i;
        lcs_pkg::SRC_F:      d_q[n] = ram_out[0];
        lcs_pkg::SRC_G:      d_q[n] = ram_out[1];
        lcs_pkg::SRC_H:      d_q[n] = h_out_o;
        default:             d_q[n] = din_lo_i;
      endcase
    end

    always_comb begin
      next_q[n] = q_o[n];
      if (force_q[n]) begin
        next_q[n] = cfg[lcs_pkg::CFG_SRVAL + n];
      end else if (cfg[lcs_pkg::CFG_LATCH + n]) begin
        if (!keff_q[n] && en_q[n]) begin
          next_q[n] = d_q[n];
        end
      end else if (edge_q[n] && en_q[n]) begin
        next_q[n] = d_q[n];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      // power-up takes the default reset value
      q_o <= 2'h0;
    end else if (ce_i) begin
      q_o <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_wr_edge;
    ce_i && capture;
  endsequence

  sequence s_pulse0;
    ce_i && wr_state == lcs_pkg::LCS_WR_PULSE && wr_en[0];
  endsequence

  property p_force;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && global_init_pulse_i |=> q_o == $past(cfg[lcs_pkg::CFG_SRVAL +: 2]);
  endproperty
  a_force: assert property (p_force) else $error("forced value not taken");

  property p_sr_unused;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && local_set_reset_i && !global_init_pulse_i && !cfg[lcs_pkg::CFG_SR_USED]
      && !cfg[lcs_pkg::CFG_LATCH] && !edge_q[0] |=> $stable(q_o[0]);
  endproperty
  a_sr_unused: assert property (p_sr_unused) else $error("unused set/reset acted");

  property p_ff_load;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !force_q[0] && !cfg[lcs_pkg::CFG_LATCH] && edge_q[0] && en_q[0]
      |=> q_o[0] == $past(d_q[0]);
  endproperty
  a_ff_load: assert property (p_ff_load) else $error("flop did not load");

  property p_ff_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !force_q[1] && !cfg[lcs_pkg::CFG_LATCH + 1] && !edge_q[1] |=> $stable(q_o[1]);
  endproperty
  a_ff_hold: assert property (p_ff_hold) else $error("flop changed between edges");

  property p_ce_low;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !force_q[0] && cfg[lcs_pkg::CFG_CE_USED] && !store_clk_en_i |=> $stable(q_o[0]);
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("disabled element changed");

  property p_ce_default;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !force_q[1] && !cfg[lcs_pkg::CFG_CE_USED + 1] && !cfg[lcs_pkg::CFG_LATCH + 1]
      && edge_q[1] |=> q_o[1] == $past(d_q[1]);
  endproperty
  a_ce_default: assert property (p_ce_default) else $error("unconnected enable blocked");

  property p_latch;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !force_q[0] && cfg[lcs_pkg::CFG_LATCH] && !keff_q[0] && en_q[0]
      |=> q_o[0] == $past(d_q[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not transparent");

  property p_capture;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_edge |=> wr_state == lcs_pkg::LCS_WR_PULSE && wr_addr[0] == $past(first_gen_addr_i)
      && wr_data[0] == $past(din_lo_i);
  endproperty
  a_capture: assert property (p_capture) else $error("write edge not captured");

  property p_ram_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_pulse0 |=> gen_ram[0].rd_wr == $past(wr_data[0]);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("RAM word not written");

  property p_sel32;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_edge ##0 mode32 |=> wr_en == {$past(din_hi_i), !$past(din_hi_i)}
      && wr_addr[1] == wr_addr[0];
  endproperty
  a_sel32: assert property (p_sel32) else $error("32x1 select wrong");

  property p_no_write_off;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && !ram_on && wr_state == lcs_pkg::LCS_WR_IDLE |=> wr_state == lcs_pkg::LCS_WR_IDLE;
  endproperty
  a_no_write_off: assert property (p_no_write_off) else $error("write with RAM off");

endmodule : lcs_cell

`default_nettype wire

// [src/lcs_pkg.sv]
package lcs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned REG_AW    = 8;
  localparam int unsigned REG_DW    = 32;
  localparam logic [7:0]  OFF_CFG   = 8'h00;
  localparam logic [7:0]  OFF_STAT  = 8'h04;

  // ---------------------------------------------------------------
  // Configuration fields (bit positions)
  // ---------------------------------------------------------------
  localparam int unsigned CFG_CLK_INV   = 0;   // 2 bits, one per element
  localparam int unsigned CFG_LATCH     = 2;   // 2 bits
  localparam int unsigned CFG_SRVAL     = 4;   // 2 bits, 1 = set
  localparam int unsigned CFG_CE_USED   = 6;   // 2 bits, 0 = enable unconnected
  localparam int unsigned CFG_SR_USED   = 8;   // 2 bits, 0 = set/reset unconnected
  localparam int unsigned CFG_WCLK_FALL = 10;  // 1 bit
  localparam int unsigned CFG_RAM_MODE  = 11;  // 2 bits
  localparam int unsigned CFG_SRC       = 13;  // 2 bits per element
  localparam int unsigned CFG_HLUT      = 17;  // 8 bits
  localparam int unsigned CFG_W         = 25;
  localparam logic [24:0] CFG_RESET     = 25'h00003c0;

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_Q     = 0;      // 2 bits
  localparam int unsigned STAT_KPREV = 2;
  localparam int unsigned STAT_WR    = 3;
  localparam int unsigned STAT_SPO   = 4;
  localparam int unsigned STAT_W     = 5;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] RAM_OFF    = 2'h0;
  localparam logic [1:0] RAM_16     = 2'h1;    // 16x2, or 16x1 using one generator
  localparam logic [1:0] RAM_32     = 2'h2;
  localparam logic [1:0] SRC_DIN_LO = 2'h0;
  localparam logic [1:0] SRC_F      = 2'h1;
  localparam logic [1:0] SRC_G      = 2'h2;
  localparam logic [1:0] SRC_H      = 2'h3;

  typedef enum logic [0:0] {
    LCS_WR_IDLE  = 1'h0,
    LCS_WR_PULSE = 1'h1
  } lcs_wr_t;

endpackage : lcs_pkg

// [tb/lcs_user_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// User logic driving the shared cell clock
// ---------------------------------------------------------------
module lcs_user_model #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clock_i,    // System clock
  input  wire logic rst_n_i,    // Synchronous reset, active low
  input  wire logic idle_i,     // Cell clock level between pulses
  input  wire logic kick_i,     // Request one cell clock pulse
  output logic      cell_clk_o  // Cell clock towards the cell
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // bounded post-edge phase
  // A kick during a pulse is dropped so the clock is never parked away from idle
  always_comb begin
    next_cnt = cnt;
    if (kick_i && cnt == 4'h0) begin
      next_cnt = 4'(HOLD);
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign cell_clk_o = (cnt != 4'h0) ? ~idle_i : idle_i;
endmodule : lcs_user_model

`default_nettype wire

// [tb/logic_cell_storage_and_sync_ram_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module logic_cell_storage_and_sync_ram_tb_top;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [31:0] rdata;
  logic        cclk;
  logic        idle = 1'b0;
  logic        kick = 1'b0;
  logic        en = 1'b0;
  logic        lsr = 1'b0;
  logic        gip = 1'b0;
  logic        dlo = 1'b0;
  logic        dhi = 1'b0;
  logic [3:0]  fa = 4'h0;
  logic [3:0]  ga = 4'h0;
  logic        rwe = 1'b0;
  logic [1:0]  q;
  logic        f_o;
  logic        g_o;
  logic        port_read_out;
  logic        h_o;
  logic        ce = 1'b1;
  logic [31:0] d;
  int          fails = 0;
  int          n_compared = 0;

  always #5 clock_i = ~clock_i;

  lcs_user_model i_lcs_user_model (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .idle_i(idle), .kick_i(kick), .cell_clk_o(cclk)
  );

  lcs_cell i_lcs_cell (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .cell_clk_i(cclk), .store_clk_en_i(en), .local_set_reset_i(lsr),
    .global_init_pulse_i(gip), .din_lo_i(dlo), .din_hi_i(dhi), .first_gen_addr_i(fa),
    .second_gen_addr_i(ga), .ram_we_i(rwe), .q_o(q), .f_out_o(f_o), .g_out_o(g_o),
    .h_out_o(h_o), .port_read_out_o(port_read_out)
  );

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    we <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock_i);
    we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    re <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  task automatic set_cfg(input logic [31:0] v);
    reg_wr(8'h00, v);
    reg_rd(8'h00, d);
    chk("cfg readback", d, v);
  endtask : set_cfg

  // Returns on the clock edge at which the model leaves idle
  task automatic kick_clk();
    @(posedge clock_i);
    kick <= 1'b1;
    @(posedge clock_i);
    kick <= 1'b0;
  endtask : kick_clk

  task automatic ram_wr(input logic [3:0] a, input logic [3:0] b, input logic lo,
                        input logic hi, input logic w);
    fa <= a;
    ga <= b;
    dlo <= lo;
    dhi <= hi;
    rwe <= w;
    kick_clk();
    cyc(7);
    rwe <= 1'b0;
  endtask : ram_wr

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    reg_rd(8'h00, d);
    chk("cfg reset", d, 32'h000003c0);
    reg_wr(8'h08, 32'hffffffff);
    reg_rd(8'h08, d);
    chk("unmapped read", d, 32'h0);
    // A strobe while the block is frozen must be lost
    ce <= 1'b0;
    reg_wr(8'h00, 32'h00000001);
    ce <= 1'b1;
    reg_rd(8'h00, d);
    chk("cfg frozen", d, 32'h000003c0);
    reg_rd(8'h04, d);
    chk("status low bits", d[3:0], 32'h0);
    chk("q reset", q, 32'h0);
  endtask : t_reset

  task automatic t_flop();
    en <= 1'b1;
    dlo <= 1'b1;
    kick_clk();
    cyc(1);
    chk("q both load", q, 32'h3);
    // Let the pulse finish, or the next kick is dropped by the model
    cyc(5);
    en <= 1'b0;
    dlo <= 1'b0;
    kick_clk();
    cyc(7);
    chk("q hold enable low", q, 32'h3);
    set_cfg(32'h00000300);
    kick_clk();
    cyc(7);
    chk("q unconnected enable", q, 32'h0);
  endtask : t_flop

  task automatic t_edge_sel();
    set_cfg(32'h000003c2);
    en <= 1'b1;
    dlo <= 1'b1;
    kick_clk();
    cyc(1);
    chk("q after rise", q, 32'h1);
    cyc(4);
    chk("q after fall", q, 32'h3);
  endtask : t_edge_sel

  task automatic t_force();
    set_cfg(32'h000003c0);
    lsr <= 1'b1;
    cyc(3);
    chk("q local reset", q, 32'h0);
    set_cfg(32'h000003f0);
    cyc(2);
    chk("q local set", q, 32'h3);
    set_cfg(32'h000000f0);
    dlo <= 1'b0;
    kick_clk();
    cyc(7);
    chk("q sr unconnected", q, 32'h0);
    set_cfg(32'h000003f0);
    lsr <= 1'b0;
    gip <= 1'b1;
    cyc(3);
    chk("q global init", q, 32'h3);
    gip <= 1'b0;
  endtask : t_force

  task automatic t_latch();
    set_cfg(32'h000003c4);
    dlo <= 1'b1;
    cyc(3);
    chk("latch open", q[0], 32'h1);
    kick_clk();
    dlo <= 1'b0;
    cyc(2);
    chk("latch closed", q[0], 32'h1);
    cyc(5);
    chk("latch reopened", q[0], 32'h0);
  endtask : t_latch

  task automatic t_ram16();
    set_cfg(32'h00000bc0);
    ram_wr(4'h5, 4'h9, 1'b1, 1'b0, 1'b1);
    ram_wr(4'h6, 4'h9, 1'b0, 1'b1, 1'b1);
    ram_wr(4'h5, 4'h9, 1'b0, 1'b0, 1'b0);
    fa <= 4'h5;
    cyc(1);
    chk("f at 5", f_o, 32'h1);
    chk("g at 9", g_o, 32'h1);
    set_cfg(32'h00100bc0);
    ga <= 4'h9;
    dhi <= 1'b0;
    cyc(1);
    chk("h of f g low pin", h_o, 32'h1);
    dhi <= 1'b1;
    cyc(1);
    chk("h of f g high pin", h_o, 32'h0);
    dhi <= 1'b0;
    fa <= 4'h6;
    cyc(1);
    chk("f at 6", f_o, 32'h0);
    set_cfg(32'h00002bc0);
    fa <= 4'h5;
    dlo <= 1'b0;
    kick_clk();
    cyc(2);
    chk("q from ram", q, 32'h1);
  endtask : t_ram16

  task automatic t_ram32();
    set_cfg(32'h000013c0);
    ram_wr(4'h3, 4'hc, 1'b1, 1'b0, 1'b1);
    ram_wr(4'h3, 4'ha, 1'b0, 1'b1, 1'b1);
    fa <= 4'h3;
    ga <= 4'h7;
    dhi <= 1'b0;
    cyc(1);
    chk("wide lower half", port_read_out, 32'h1);
    dhi <= 1'b1;
    cyc(1);
    chk("wide upper half", port_read_out, 32'h0);
  endtask : t_ram32

  task automatic t_wfall();
    set_cfg(32'h00000fc0);
    fa <= 4'h5;
    ga <= 4'h9;
    dlo <= 1'b0;
    dhi <= 1'b0;
    rwe <= 1'b1;
    kick_clk();
    cyc(3);
    chk("f before fall", f_o, 32'h1);
    chk("g before fall", g_o, 32'h1);
    cyc(5);
    chk("f after fall", f_o, 32'h0);
    chk("g after fall", g_o, 32'h0);
    rwe <= 1'b0;
  endtask : t_wfall

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_flop();
    t_edge_sel();
    t_force();
    t_latch();
    t_ram16();
    t_ram32();
    t_wfall();
    end_sim();
  end

  // Whole run is about two hundred cycles; this leaves a wide margin
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule : logic_cell_storage_and_sync_ram_tb_top

`default_nettype wire
